// [include/servo_seq_pkg.sv]
package servo_seq_pkg;
  // Clock rate and the 10 ms unit used by the delay and timeout settings.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned PRE_W = 22;

  // Register byte offsets.
  localparam logic [5:0] OFS_ZERO_LVL = 6'h00;
  localparam logic [5:0] OFS_CONTROL = 6'h04;
  localparam logic [5:0] OFS_OFF_DELAY = 6'h08;
  localparam logic [5:0] OFS_BRK_SPD = 6'h0C;
  localparam logic [5:0] OFS_BRK_TMO = 6'h10;
  localparam logic [5:0] OFS_STATUS = 6'h14;
  localparam logic [5:0] OFS_PANEL_CLR = 6'h18;

  // Field positions in the control and status registers.
  localparam int unsigned POS_METHOD = 0;
  localparam int unsigned POS_ALLOC = 4;
  localparam int unsigned POS_ROUTE = 8;
  localparam int unsigned POS_MOTOR = 0;
  localparam int unsigned POS_BRAKE = 1;
  localparam int unsigned POS_FAULT = 2;
  localparam int unsigned POS_CLAMP = 3;
  localparam int unsigned POS_CODE = 4;
  localparam int unsigned POS_ENC = 7;

  // Ranges and reset values of the settings.
  localparam logic [13:0] SPD_MAX = 14'h2710;
  localparam logic [13:0] ZERO_LVL_RST = 14'h000A;
  localparam logic [3:0] METHOD_SPEED = 4'h0;
  localparam logic [3:0] METHOD_CLAMP = 4'hA;
  localparam logic [3:0] METHOD_RST = 4'h0;
  localparam logic ALLOC_RST = 1'b0;
  localparam logic [1:0] ROUTE_RST = 2'h0;
  localparam logic [13:0] DELAY_MAX = 14'h0032;
  localparam logic [5:0] DELAY_RST = 6'h00;
  localparam logic [13:0] BRK_SPD_RST = 14'h0064;
  localparam logic [13:0] TMO_MAX = 14'h0064;
  localparam logic [6:0] TMO_RST = 7'h32;

  typedef struct packed {
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avmm_rsp_t;

  typedef struct packed {
    logic valid;
    logic [2:0] code;
    logic encoder;
  } fault_req_t;

  typedef enum logic [1:0] {SV_RUN, SV_HOLD, SV_COAST, SV_OFF} servo_st_t;
endpackage

// [rtl/tick_timer.sv]
`timescale 1ns/1ps
module tick_timer #(
  parameter int unsigned TICK_CYC = servo_seq_pkg::TICK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic [6:0] units_i,
  output logic expired_o
);
  import servo_seq_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [6:0] cnt;
    logic run;
    logic exp;
  } tmr_t;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);
  tmr_t q, d;

  always_comb begin
    d = q;
    if (start_i) begin
      d.pre = '0;
      d.cnt = units_i;
      d.run = (units_i != 7'h00);
      d.exp = (units_i == 7'h00);
    end else if (q.run) begin
      if (q.pre == PRE_LAST) begin
        d.pre = '0;
        d.cnt = q.cnt - 7'h01;
        if (q.cnt == 7'h01) begin
          d.run = 1'b0;
          d.exp = 1'b1;
        end
      end else begin
        d.pre = q.pre + PRE_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired_o = q.exp;

  tick_expiry_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R8]
    $rose(expired_o) && !$past(start_i) |-> $past(q.pre) == PRE_LAST && $past(q.cnt) == 7'h01)
    else $error("Timer expired off a tick boundary.");
endmodule // tick_timer

// [rtl/fault_latch.sv]
`timescale 1ns/1ps
module fault_latch (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire servo_seq_pkg::fault_req_t req_i,
  input wire logic clear_i,
  output logic active_o,
  output logic [2:0] code_o,
  output logic encoder_o
);
  import servo_seq_pkg::*;

  typedef struct packed {
    logic active;
    logic [2:0] code;
    logic enc;
  } fault_t;

  fault_t q, d;

  // A new fault in the clear cycle wins, so no event is lost.
  always_comb begin
    d = q;
    if (req_i.valid) begin
      d.active = 1'b1;
      d.enc = q.enc | req_i.encoder;
      if (!q.active) begin
        d.code = req_i.code;
        d.enc = req_i.encoder;
      end
    end else if (clear_i && !q.enc) begin // [R17] [R19]
      d = '0;
    end
  end

  // Control power loss is the reset, which drops every latched fault.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      q <= '0; // [R18]
    end else begin
      q <= d;
    end
  end

  assign active_o = q.active;
  assign code_o = q.code;
  assign encoder_o = q.enc;

  sequence fault_raised;
    req_i.valid;
  endsequence

  sequence fault_gone;
    !active_o ##1 !active_o;
  endsequence

  set_wins_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R17]
    fault_raised |=> active_o)
    else $error("Fault lost in the clear cycle.");

  enc_hold_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R19]
    encoder_o && clear_i && !req_i.valid |=> active_o ##1 active_o)
    else $error("Encoder fault cleared by the reset input.");

  clear_done_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R17]
    active_o && !encoder_o && clear_i && !req_i.valid |=> fault_gone or req_i.valid)
    else $error("Fault not cleared by the reset input.");
endmodule // fault_latch

// [rtl/servo_stop_brake_alarm_sequencer.sv]
// What this block does
// [R1] Zero clamp level 0 to 10000, default 10.
// [R2] Clamp level limited to motor maximum speed.
// [R3] Clamp needs method A, input, low reference.
// [R4] Allocated clamp input also works in method 0.
// [R5] Brake pin low releases, high applies.
// [R6] Route field 0 none, 1 to 3 circuits.
// [R7] Shared output circuit is OR of functions.
// [R8] Stopped servo off waits delay before cut.
// [R9] Zero delay cuts with brake apply.
// [R10] Alarm cuts motor output at once.
// [R11] Brake speed threshold 0 to 10000, default 100.
// [R12] Brake timeout 0 to 100 units, default 50.
// [R13] Moving stop applies brake at slow or timeout.
// [R14] Brake threshold limited to motor maximum speed.
// [R15] Fault pin low normal, high on alarm.
// [R16] Three code lines show fault type.
// [R17] Reset input clears latched fault.
// [R18] Power loss clears all latched faults.
// [R19] Encoder faults ignore the reset input.
// [R20] Panel clear acts like the reset input.
// [R21] Outside circuit turns amplifier off on fault.
// [R22] Servo off on input, alarm or power loss.
// [R23] Speed compares use magnitude only.
`timescale 1ns/1ps
module servo_stop_brake_alarm_sequencer #(
  parameter int unsigned TICK_CYC = servo_seq_pkg::TICK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire servo_seq_pkg::avmm_req_t avmm_i,
  output servo_seq_pkg::avmm_rsp_t avmm_o,
  input wire logic servo_on_i,
  input wire logic power_fail_i,
  input wire logic signed [15:0] speed_ref_i,
  input wire logic signed [15:0] motor_speed_i,
  input wire logic [13:0] max_speed_i,
  input wire logic zero_hold_input_n_i,
  input wire logic fault_clear_input_i,
  input wire servo_seq_pkg::fault_req_t fault_req_i,
  input wire logic [2:0] other_func_i,
  output logic zero_hold_o,
  output logic motor_enable_o,
  output logic brake_release_out_o,
  output logic [2:0] out_circuit_o,
  output logic servo_fault_out_o,
  output logic [2:0] fault_code_o
);
  import servo_seq_pkg::*;

  typedef struct packed {
    logic [13:0] zero_lvl;
    logic [3:0] method;
    logic alloc;
    logic [1:0] route;
    logic [5:0] delay;
    logic [13:0] bspd;
    logic [6:0] btmo;
    servo_st_t st;
    logic ack;
    logic [31:0] rdata;
    logic panel_clr;
    logic start;
    logic [6:0] units;
    logic zero_hold;
    logic motor_en;
    logic brake_rel;
    logic [2:0] circ;
  } seq_t;

  localparam seq_t SEQ_RST = '{
    zero_lvl: ZERO_LVL_RST,
    method: METHOD_RST,
    alloc: ALLOC_RST,
    route: ROUTE_RST,
    delay: DELAY_RST,
    bspd: BRK_SPD_RST,
    btmo: TMO_RST,
    st: SV_OFF,
    ack: 1'b0,
    rdata: 32'h0000_0000,
    panel_clr: 1'b0,
    start: 1'b0,
    units: 7'h00,
    zero_hold: 1'b0,
    motor_en: 1'b0,
    brake_rel: 1'b0,
    circ: 3'h7
  };

  seq_t q, d;
  logic fault_act;
  logic fault_enc;
  logic [2:0] fault_code;
  logic tmr_exp;
  logic req_any;
  logic off_cause;
  logic slow;
  logic ref_low;

  // Speed magnitude, so both turning directions compare alike.
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // A setting above the motor's top speed falls back to that top speed.
  function automatic logic [15:0] eff(input logic [13:0] cfg, input logic [13:0] top);
    eff = {2'b00, (cfg > top) ? top : cfg};
  endfunction

  // Writes above the range saturate rather than wrap.
  function automatic logic [13:0] sat(input logic [31:0] v, input logic [13:0] top);
    sat = (v > {18'h0_0000, top}) ? top : v[13:0];
  endfunction

  assign req_any = avmm_i.read | avmm_i.write;
  assign off_cause = !servo_on_i || fault_act || power_fail_i; // [R22]
  assign slow = mag(motor_speed_i) < eff(q.bspd, max_speed_i); // [R14] [R23]
  assign ref_low = mag(speed_ref_i) < eff(q.zero_lvl, max_speed_i); // [R2] [R23]

  always_comb begin
    d = q;
    d.start = 1'b0;
    d.units = 7'h00;
    d.panel_clr = 1'b0;
    d.ack = req_any & ~q.ack;
    d.rdata = 32'h0000_0000;
    if (d.ack && avmm_i.read) begin
      case (avmm_i.address)
        OFS_ZERO_LVL: d.rdata = 32'(q.zero_lvl);
        OFS_CONTROL: begin
          d.rdata[POS_METHOD +: 4] = q.method;
          d.rdata[POS_ALLOC] = q.alloc;
          d.rdata[POS_ROUTE +: 2] = q.route;
        end
        OFS_OFF_DELAY: d.rdata = 32'(q.delay);
        OFS_BRK_SPD: d.rdata = 32'(q.bspd);
        OFS_BRK_TMO: d.rdata = 32'(q.btmo);
        OFS_STATUS: begin
          d.rdata[POS_MOTOR] = q.motor_en;
          d.rdata[POS_BRAKE] = q.brake_rel;
          d.rdata[POS_FAULT] = fault_act;
          d.rdata[POS_CLAMP] = q.zero_hold;
          d.rdata[POS_CODE +: 3] = fault_code;
          d.rdata[POS_ENC] = fault_enc;
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (q.ack && avmm_i.write) begin
      case (avmm_i.address)
        OFS_ZERO_LVL: d.zero_lvl = sat(avmm_i.writedata, SPD_MAX); // [R1]
        OFS_CONTROL: begin
          d.method = avmm_i.writedata[POS_METHOD +: 4];
          d.alloc = avmm_i.writedata[POS_ALLOC];
          d.route = avmm_i.writedata[POS_ROUTE +: 2]; // [R6]
        end
        OFS_OFF_DELAY: d.delay = 6'(sat(avmm_i.writedata, DELAY_MAX)); // [R8]
        OFS_BRK_SPD: d.bspd = sat(avmm_i.writedata, SPD_MAX); // [R11]
        OFS_BRK_TMO: d.btmo = 7'(sat(avmm_i.writedata, TMO_MAX)); // [R12]
        OFS_PANEL_CLR: d.panel_clr = avmm_i.writedata[0]; // [R20]
        default: d.panel_clr = 1'b0;
      endcase
    end

    unique case (q.st)
      SV_RUN: begin
        d.motor_en = 1'b1;
        d.brake_rel = 1'b1;
        if (off_cause) begin
          if (slow) begin
            d.brake_rel = 1'b0;
            if (fault_act || q.delay == 6'h00) begin // [R9] [R10]
              d.motor_en = 1'b0;
              d.st = SV_OFF;
            end else begin
              d.start = 1'b1; // [R8]
              d.units = 7'(q.delay);
              d.st = SV_HOLD;
            end
          end else begin
            d.motor_en = 1'b0;
            if (q.btmo == 7'h00) begin
              d.brake_rel = 1'b0;
              d.st = SV_OFF;
            end else begin
              d.start = 1'b1; // [R13]
              d.units = q.btmo;
              d.st = SV_COAST;
            end
          end
        end
      end
      SV_HOLD: begin
        if (fault_act || tmr_exp) begin // [R8] [R10]
          d.motor_en = 1'b0;
          d.st = SV_OFF;
        end
      end
      SV_COAST: begin
        if (slow || tmr_exp) begin // [R13]
          d.brake_rel = 1'b0;
          d.st = SV_OFF;
        end
      end
      SV_OFF: begin
        d.motor_en = 1'b0;
        d.brake_rel = 1'b0;
        if (!off_cause) begin
          d.motor_en = 1'b1;
          d.brake_rel = 1'b1;
          d.st = SV_RUN;
        end
      end
    endcase

    // The clamp input pin is active low; method 0 joins only when allocated.
    d.zero_hold = !zero_hold_input_n_i && ref_low // [R3]
      && (q.method == METHOD_CLAMP || (q.alloc && q.method == METHOD_SPEED)); // [R4]

    // Pins are low while a function holds them on.
    for (int i = 0; i < 3; i++) begin
      d.circ[i] = !(other_func_i[i] || (d.brake_rel && q.route == 2'(i + 1))); // [R6] [R7]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      q <= SEQ_RST;
    end else begin
      q <= d;
    end
  end

  tick_timer #(
    .TICK_CYC(TICK_CYC)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(d.start),
    .units_i(d.units),
    .expired_o(tmr_exp)
  );

  fault_latch u_fault (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .req_i(fault_req_i),
    .clear_i(fault_clear_input_i | q.panel_clr), // [R17] [R20]
    .active_o(fault_act),
    .code_o(fault_code),
    .encoder_o(fault_enc)
  );

  assign avmm_o.readdata = q.rdata;
  assign avmm_o.waitrequest = req_any & ~q.ack;
  assign zero_hold_o = q.zero_hold;
  assign motor_enable_o = q.motor_en;
  assign brake_release_out_o = !q.brake_rel; // [R5]
  assign out_circuit_o = q.circ;
  // The fault pin is the latch flop itself, high while a fault is held.
  assign servo_fault_out_o = fault_act; // [R15] [R21]
  assign fault_code_o = fault_code; // [R16]

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence off_while_slow;
    q.st == SV_RUN && off_cause && slow;
  endsequence

  clamp_gate_a: assert property ( // [R3]
    q.method != METHOD_CLAMP && !(q.alloc && q.method == METHOD_SPEED) |=> !zero_hold_o)
    else $error("Zero clamp engaged in a wrong control method.");

  clamp_speed_a: assert property ( // [R4]
    q.alloc && q.method == METHOD_SPEED && !zero_hold_input_n_i && ref_low |=> zero_hold_o)
    else $error("Allocated clamp input ignored in speed control.");

  no_delay_cut_a: assert property ( // [R9]
    off_while_slow and q.delay == 6'h00 |=> brake_release_out_o && !motor_enable_o)
    else $error("Motor cut not aligned with brake apply.");

  alarm_cut_a: assert property ( // [R10]
    (q.st == SV_RUN || q.st == SV_HOLD) && fault_act |=> !motor_enable_o)
    else $error("Alarm did not cut motor output at once.");

  hold_delay_a: assert property ( // [R8]
    off_while_slow and q.delay != 6'h00 and !fault_act
      |=> brake_release_out_o && motor_enable_o ##1 q.st != SV_RUN)
    else $error("Motor cut before the brake delay ran.");

  coast_brake_a: assert property ( // [R13]
    q.st == SV_COAST && slow |=> brake_release_out_o && q.st == SV_OFF)
    else $error("Brake not applied when speed fell below level.");

  run_release_a: assert property ( // [R5]
    q.st == SV_RUN |-> !brake_release_out_o && motor_enable_o)
    else $error("Brake pin not releasing while running.");

  route_or_a: assert property ( // [R7]
    other_func_i[0] |=> !out_circuit_o[0])
    else $error("Shared circuit missed an allocated function.");

  bus_answer_a: assert property (
    req_any |-> ##[0:1] !avmm_o.waitrequest)
    else $error("Register access not answered within one cycle.");

  read_quiet_a: assert property (
    !q.ack |-> avmm_o.readdata == 32'h0000_0000)
    else $error("Read data shown outside a read answer.");

  route_none_a: assert property ( // [R6]
    q.route == 2'h0 && other_func_i == 3'h0 |=> out_circuit_o == 3'h7)
    else $error("Brake reached a circuit with no route selected.");

  // The routed pin follows the brake pin one edge behind the route it was set from.
  route_brake_a: assert property ( // [R6] [R7]
    q.route == 2'h1 |=> out_circuit_o[0] == (brake_release_out_o && !$past(other_func_i[0])))
    else $error("Routed circuit does not follow the brake output.");

  clamp_off_a: assert property ( // [R3]
    zero_hold_input_n_i |=> !zero_hold_o)
    else $error("Zero clamp engaged with the clamp input off.");

  alarm_code_a: assert property ( // [R16]
    fault_req_i.valid && !fault_act |=> fault_code_o == $past(fault_req_i.code))
    else $error("Fault code lines do not show the first fault.");

  coast_cut_a: assert property ( // [R13]
    q.st == SV_RUN && off_cause && !slow |=> !motor_enable_o && q.st != SV_RUN)
    else $error("Motor output kept on after a moving servo off.");

  coast_timeout_a: assert property ( // [R13]
    q.st == SV_COAST && tmr_exp |=> brake_release_out_o && q.st == SV_OFF)
    else $error("Brake not applied when the moving timeout ran out.");

  hold_keep_a: assert property ( // [R8]
    q.st == SV_HOLD && !fault_act && !tmr_exp |=> motor_enable_o && brake_release_out_o)
    else $error("Hold state left before its delay ran out.");

  power_stop_a: assert property ( // [R22]
    q.st == SV_RUN && power_fail_i |=> q.st != SV_RUN)
    else $error("Power loss did not start a servo off.");
endmodule // servo_stop_brake_alarm_sequencer

// [tb/host_relay_model.sv]
`timescale 1ns/1ps
module host_relay_model (
  input wire logic sys_clk_i,
  input wire logic run_cmd_i,
  input wire logic clear_cmd_i,
  input wire logic fault_pin_i,
  input wire logic brake_pin_i,
  output logic servo_on_o,
  output logic clear_o,
  output logic brake_held_o
);
  // The host drops servo on while the fault pin is high and passes each clear on one edge later.
  always_ff @(posedge sys_clk_i) begin
    servo_on_o <= run_cmd_i & !fault_pin_i;
    clear_o <= clear_cmd_i;
  end
  // The relay holds the axis while the brake pin is open.
  assign brake_held_o = brake_pin_i;
endmodule // host_relay_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import servo_seq_pkg::*;
  localparam int unsigned TK = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  avmm_req_t bus_q = '0;
  avmm_rsp_t rsp;
  fault_req_t flt = '0;
  logic run_cmd = 1'b1;
  logic clr_cmd = 1'b0;
  logic pwr_fail = 1'b0;
  logic zin_n = 1'b1;
  logic signed [15:0] sref = '0;
  logic signed [15:0] mspd = '0;
  logic [13:0] maxs = SPD_MAX;
  logic [2:0] other = '0;
  logic zh, men, brk, fo, son, clr, held;
  logic [2:0] oc, fc;
  int mismatches = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  servo_stop_brake_alarm_sequencer #(.TICK_CYC(TK)) dut (.sys_clk_i(clk), .reset_n_i(rst_n),
    .avmm_i(bus_q), .avmm_o(rsp), .servo_on_i(son), .power_fail_i(pwr_fail),
    .speed_ref_i(sref), .motor_speed_i(mspd), .max_speed_i(maxs), .zero_hold_input_n_i(zin_n),
    .fault_clear_input_i(clr), .fault_req_i(flt), .other_func_i(other), .zero_hold_o(zh),
    .motor_enable_o(men), .brake_release_out_o(brk), .out_circuit_o(oc),
    .servo_fault_out_o(fo), .fault_code_o(fc));
  host_relay_model partner (.sys_clk_i(clk), .run_cmd_i(run_cmd), .clear_cmd_i(clr_cmd),
    .fault_pin_i(fo), .brake_pin_i(brk), .servo_on_o(son), .clear_o(clr), .brake_held_o(held));
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    bus_q <= '{address: a, read: !w, write: w, writedata: d};
    do begin
      @(posedge clk);
    end while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    bus_q.read <= 1'b0;
    bus_q.write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_men(input logic v);
    int n;
    n = 0;
    while (men !== v && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(32'(men), 32'(v));
  endtask
  // Starts a servo off and returns once the motor output has been cut.
  task automatic go_off(input logic signed [15:0] spd);
    @(posedge clk);
    mspd <= spd;
    run_cmd <= 1'b0;
    wait_men(1'b0);
  endtask
  task automatic go_on();
    @(posedge clk);
    run_cmd <= 1'b1;
    mspd <= 16'sh0000;
    wait_men(1'b1);
  endtask
  task automatic t_regs();
    rd(OFS_ZERO_LVL, 32'(ZERO_LVL_RST));
    rd(OFS_OFF_DELAY, 32'(DELAY_RST));
    rd(OFS_BRK_SPD, 32'(BRK_SPD_RST));
    rd(OFS_BRK_TMO, 32'(TMO_RST));
    rd(6'h1C, 32'h0000_0000);
    wr(OFS_ZERO_LVL, 32'h0000_FFFF);
    rd(OFS_ZERO_LVL, 32'(SPD_MAX));
    wr(OFS_BRK_TMO, 32'h0000_00C8);
    rd(OFS_BRK_TMO, 32'(TMO_MAX));
    wr(OFS_ZERO_LVL, 32'h0000_000A);
  endtask
  task automatic clamp(input logic [31:0] ctl, input logic zn, input logic signed [15:0] r,
                       input logic [13:0] mx, input logic exp);
    wr(OFS_CONTROL, ctl);
    @(posedge clk);
    zin_n <= zn;
    sref <= r;
    maxs <= mx;
    cyc(3);
    chk(32'(zh), 32'(exp));
  endtask
  task automatic t_clamp();
    clamp(32'h0000_000A, 1'b0, 16'sd5, SPD_MAX, 1'b1);
    clamp(32'h0000_000A, 1'b0, -16'sd5, SPD_MAX, 1'b1);
    clamp(32'h0000_000A, 1'b0, 16'sd10, SPD_MAX, 1'b0);
    clamp(32'h0000_000A, 1'b1, 16'sd5, SPD_MAX, 1'b0);
    clamp(32'h0000_000A, 1'b0, 16'sd5, 14'h0003, 1'b0);
    clamp(32'h0000_0000, 1'b0, 16'sd5, SPD_MAX, 1'b0);
    clamp(32'h0000_0010, 1'b0, 16'sd5, SPD_MAX, 1'b1);
  endtask
  task automatic t_route();
    for (int r = 0; r < 4; r++) begin
      wr(OFS_CONTROL, 32'(r) << POS_ROUTE);
      cyc(2);
      chk(32'(oc), 32'h0000_0007 ^ ((32'h0000_0002 << r) >> 2));
    end
    wr(OFS_CONTROL, 32'h0000_0200);
    rd(OFS_CONTROL, 32'h0000_0200);
    @(posedge clk);
    other <= 3'b001;
    cyc(2);
    chk(32'(oc), 32'h0000_0004);
    @(posedge clk);
    other <= 3'b000;
  endtask
  task automatic t_stop();
    wr(OFS_OFF_DELAY, 32'h0000_0002);
    @(posedge clk);
    run_cmd <= 1'b0;
    while (brk !== 1'b1 && men === 1'b1) @(negedge clk);
    chk(32'({held, men}), 32'h0000_0003);
    cyc(2 * TK - 2);
    chk(32'(men), 32'h0000_0001);
    cyc(4);
    chk(32'(men), 32'h0000_0000);
    go_on();
    wr(OFS_OFF_DELAY, 32'h0000_0000);
    go_off(16'sd0);
    chk(32'(brk), 32'h0000_0001);
    go_on();
    @(posedge clk);
    pwr_fail <= 1'b1;
    cyc(3);
    chk(32'(men), 32'h0000_0000);
    @(posedge clk);
    pwr_fail <= 1'b0;
    wait_men(1'b1);
  endtask
  task automatic t_moving();
    go_off(16'sd500);
    chk(32'(brk), 32'h0000_0000);
    cyc(4);
    chk(32'(brk), 32'h0000_0000);
    @(posedge clk);
    mspd <= -16'sd50;
    cyc(3);
    chk(32'(brk), 32'h0000_0001);
    go_on();
    wr(OFS_BRK_TMO, 32'h0000_0002);
    go_off(16'sd500);
    cyc(2 * TK - 3);
    chk(32'(brk), 32'h0000_0000);
    cyc(5);
    chk(32'(brk), 32'h0000_0001);
    go_on();
    wr(OFS_BRK_SPD, 32'h0000_00C8);
    @(posedge clk);
    maxs <= 14'h0096;
    go_off(-16'sd170);
    chk(32'(brk), 32'h0000_0000);
    go_on();
    @(posedge clk);
    maxs <= SPD_MAX;
  endtask
  task automatic fault(input logic [2:0] c, input logic e);
    @(posedge clk);
    flt <= '{valid: 1'b1, code: c, encoder: e};
    @(posedge clk);
    flt.valid <= 1'b0;
    cyc(2);
  endtask
  task automatic t_faults();
    wr(OFS_OFF_DELAY, 32'h0000_0002);
    for (int c = 1; c < 8; c++) begin
      fault(3'(c), 1'b0);
      chk(32'({fo, fc, men}), 32'(c * 2 + 16));
      chk(32'(fc), 32'(c));
      if (c == 3) rd(OFS_STATUS, 32'h0000_0034);
      if (c % 2 == 1) begin
        wr(OFS_PANEL_CLR, 32'h0000_0001);
      end else begin
        @(posedge clk);
        clr_cmd <= 1'b1;
        cyc(3);
        @(posedge clk);
        clr_cmd <= 1'b0;
      end
      cyc(2);
      chk(32'({fo, fc}), 32'h0000_0000);
      wait_men(1'b1);
    end
    fault(3'h2, 1'b1);
    @(posedge clk);
    clr_cmd <= 1'b1;
    cyc(4);
    chk(32'(fo), 32'h0000_0001);
    @(posedge clk);
    clr_cmd <= 1'b0;
    rd(OFS_STATUS, 32'h0000_00A4);
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    chk(32'({fo, fc}), 32'h0000_0000);
    rd(OFS_OFF_DELAY, 32'(DELAY_RST));
  endtask
  initial begin
    #400_000;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wait_men(1'b1);
    t_regs();
    t_clamp();
    t_route();
    t_stop();
    t_moving();
    t_faults();
    stop_test();
  end
endmodule // tb_top
